// [dpt_pkg.sv]
package dpt_pkg;

  // ----------------------------------------------------------
  // register indexes, byte address is four times the index
  // ----------------------------------------------------------
  localparam logic [7:0] IDX_MODE = 8'hf1;
  localparam logic [7:0] IDX_CNT1 = 8'hf2;
  localparam logic [7:0] IDX_DIV1 = 8'hf3;
  localparam logic [7:0] IDX_CNT0 = 8'hf4;
  localparam logic [7:0] IDX_DIV0 = 8'hf5;
  localparam logic [7:0] IDX_STAT = 8'he0;
  localparam logic [7:0] IDX_MASK = 8'he1;
  localparam logic [7:0] IDX_CFG  = 8'he2;

  // ----------------------------------------------------------
  // field positions
  // ----------------------------------------------------------
  localparam int unsigned MODE_LOAD0   = 0;
  localparam int unsigned MODE_EN0     = 1;
  localparam int unsigned MODE_LOAD1   = 2;
  localparam int unsigned MODE_EN1     = 3;
  localparam int unsigned MODE_IN_LSB  = 4;
  localparam int unsigned MODE_OUT_LSB = 6;
  localparam int unsigned PRE_CONT     = 0;
  localparam int unsigned PRE_SRC      = 1;
  localparam int unsigned PRE_DIV_LSB  = 2;
  localparam int unsigned CFG_CASCADE  = 0;

  // ----------------------------------------------------------
  // field encodings and reset values
  // ----------------------------------------------------------
  localparam logic [1:0] TIN_EXTCLK = 2'h0;
  localparam logic [1:0] TIN_GATE   = 2'h1;
  localparam logic [1:0] TIN_TRIG   = 2'h2;
  localparam logic [1:0] TIN_RETRIG = 2'h3;
  localparam logic [1:0] OUT_OFF    = 2'h0;
  localparam logic [1:0] OUT_ZERO   = 2'h1;
  localparam logic [1:0] OUT_ONE    = 2'h2;
  localparam logic [1:0] OUT_CLK    = 2'h3;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] PRE_RESET  = 8'h00;
  localparam logic [7:0] CNT_RESET  = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // ----------------------------------------------------------
  // timing: internal timer clock is the system clock over four
  // ----------------------------------------------------------
  localparam int unsigned INT_CLK_DIV  = 4;
  localparam logic [1:0]  INT_DIV_LAST = 2'(INT_CLK_DIV - 1);

  typedef enum logic [1:0] {CH_IDLE, CH_WAIT, CH_RUN} dpt_state_t;

endpackage

// [dpt_chan_if.sv]
`timescale 1ns/1ps
// control from the register file to one counter channel and back
interface dpt_chan_if;
  logic       tick;
  logic       load;
  logic       enable;
  logic       cont;
  logic       trigMode;
  logic       trigEdge;
  logic       retrig;
  logic [5:0] preDiv;
  logic [7:0] initCount;
  logic [7:0] count;
  logic       eoc;

  modport ctl (
    output tick, load, enable, cont, trigMode, trigEdge, retrig,
    output preDiv, initCount,
    input  count, eoc
  );
  modport chan (
    input  tick, load, enable, cont, trigMode, trigEdge, retrig,
    input  preDiv, initCount,
    output count, eoc
  );
endinterface

// [dpt_channel.sv]
`timescale 1ns/1ps
module dpt_channel (
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // control and status
  dpt_chan_if.chan  ch
);

  dpt_pkg::dpt_state_t state;
  logic [5:0]          preCnt;
  logic                run;
  logic                trigStart;

  // counting only while enabled, started and given a source tick
  assign run = ch.enable && (state == dpt_pkg::CH_RUN) && ch.tick; // [R6]
  // a waiting channel starts on an edge; retrigger also restarts
  assign trigStart = ch.trigMode && ch.trigEdge &&
                     ((state == dpt_pkg::CH_WAIT) ||
                      (ch.retrig && state == dpt_pkg::CH_RUN)); // [R10]
  // end of count needs both prescaler and counter at their last step
  assign ch.eoc = run && !ch.load && !trigStart &&
                  (preCnt == 6'h01) && (ch.count == 8'h01); // [R5]

  // run state; load restarts, single pass halts at the end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= dpt_pkg::CH_IDLE;
    end else if (ch.load) begin
      state <= ch.trigMode ? dpt_pkg::CH_WAIT : dpt_pkg::CH_RUN; // [R6]
    end else if (trigStart) begin
      state <= dpt_pkg::CH_RUN;
    end else begin
      case (state)
        dpt_pkg::CH_RUN: begin
          if (ch.eoc && !ch.cont) begin // [R7]
            state <= ch.trigMode ? dpt_pkg::CH_WAIT : dpt_pkg::CH_IDLE;
          end
        end
        dpt_pkg::CH_IDLE: state <= dpt_pkg::CH_IDLE;
        dpt_pkg::CH_WAIT: state <= dpt_pkg::CH_WAIT;
        default: state <= dpt_pkg::CH_IDLE;
      endcase
    end
  end

  // prescaler and counter; zero wraps so it counts 64 or 256 steps
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      preCnt   <= 6'h00;
      ch.count <= dpt_pkg::CNT_RESET;
    end else if (ch.load || trigStart) begin
      preCnt   <= ch.preDiv; // [R16]
      ch.count <= ch.initCount; // [R4]
    end else if (run) begin
      if (preCnt == 6'h01) begin
        preCnt <= ch.preDiv; // [R3]
        if (ch.eoc && ch.cont) begin
          ch.count <= ch.initCount; // [R7]
        end else begin
          ch.count <= ch.count - 8'h01; // [R1] [R4]
        end
      end else begin
        preCnt <= preCnt - 6'h01; // [R1] [R3]
      end
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence singleEnd;
    ch.eoc && !ch.cont;
  endsequence

  single_halt_a: assert property ( // [R7]
    singleEnd |=> ch.count == 8'h00 && state != dpt_pkg::CH_RUN)
    else $error("single pass did not halt at zero");
  cont_reload_a: assert property ( // [R7]
    ch.eoc && ch.cont |=> ch.count == $past(ch.initCount))
    else $error("continuous mode did not reload");
  pre_reload_a: assert property ( // [R3]
    run && preCnt == 6'h01 && !ch.load |=> preCnt == $past(ch.preDiv))
    else $error("prescaler did not reload its divisor");
  count_cause_a: assert property ( // [R4]
    !$stable(ch.count) |-> $past(run || ch.load || trigStart))
    else $error("count moved without a tick or load");
  wait_quiet_a: assert property ( // [R10]
    state == dpt_pkg::CH_WAIT |-> !ch.eoc)
    else $error("end of count while waiting for trigger");

endmodule

// [dpt_timer.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Functional notes
// R1: two independent 8-bit down counters, each with a 6-bit prescaler
// R2: timer zero runs on internal clock; timer one internal or external
// R3: prescaler divides by any integer from 1 through 64
// R4: prescaler output decrements its counter from a loaded 1 to 256
// R5: end of prescaler and counter raises that timer's end request
// R6: software starts, stops, resumes or restarts each counter
// R7: single pass halts at zero; continuous mode reloads and goes on
// R8: count reads never disturb count or mode; prescalers read zero
// R9: timer one source is internal clock over four or external input
// R10: timer input acts as clock, retrigger, one-shot trigger or gate
// R11: timer output line carries timer zero, timer one or clock
// R12: timer zero end of count may clock timer one
// R13: timer one prescaler register is write-only at index f3
// R14: timer one count register is read/write at index f2
// R15: timer mode control register is read/write at index f1
// R16: loaded zero counts 256; prescaler zero divides by 64
// R17: selected timer toggles the output line at each end of count
// ------------------------------------------------------------
module dpt_timer (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output      logic        ack_o,
  output      logic [31:0] dat_o,
  // interrupts
  output      logic        irq,
  output      logic        timerZeroEndRequest,
  output      logic        timerOneEndRequest,
  // port pins
  input  wire logic        port3Line1TimerInput,
  output      logic        port3Line6TimerOutput,
  output      logic        port3Line6TimerOutputEn
);

  dpt_chan_if c0 ();
  dpt_chan_if c1 ();

  logic [7:0]  mode;
  logic [7:0]  div0;
  logic [7:0]  div1;
  logic [7:0]  init0;
  logic [7:0]  init1;
  logic [1:0]  stat;
  logic [1:0]  mask;
  logic        cascade;
  logic        load0;
  logic        load1;
  logic [1:0]  intDiv;
  logic        intTick;
  logic        tinMeta;
  logic        tinSync;
  logic        tinLast;
  logic        tinEdge;
  logic        outFlip;
  logic [7:0]  idx;
  logic        wbReq;
  logic        wr;
  logic        rd;
  logic [7:0]  rdData;
  logic [1:0]  next_stat;
  logic        t1Internal;
  logic        gateOk;

  // ----------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------
  // the low byte lane carries all data; other lanes read zero
  assign idx   = adr_i[9:2];
  assign wbReq = cyc_i && stb_i && !ack_o;
  assign wr    = wbReq && we_i && sel_i[0];
  assign rd    = wbReq && !we_i;

  // single wait state answer, unmapped addresses ack with zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= wbReq;
    end
  end

  // read mux; prescalers and load strobes read back as zero
  always_comb begin
    rdData = 8'h00;
    case (idx)
      dpt_pkg::IDX_MODE: rdData = mode; // [R15]
      dpt_pkg::IDX_CNT1: rdData = c1.count; // [R14] [R8]
      dpt_pkg::IDX_CNT0: rdData = c0.count; // [R8]
      dpt_pkg::IDX_DIV1: rdData = 8'h00; // [R13] [R8]
      dpt_pkg::IDX_DIV0: rdData = 8'h00; // [R8]
      dpt_pkg::IDX_STAT: rdData = {6'h00, stat};
      dpt_pkg::IDX_MASK: rdData = {6'h00, mask};
      dpt_pkg::IDX_CFG:  rdData = {7'h00, cascade};
      default:           rdData = 8'h00;
    endcase
  end

  // read data is held until the next read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dat_o <= 32'h0000_0000;
    end else if (rd) begin
      dat_o <= {24'h00_0000, rdData};
    end
  end

  // ----------------------------------------------------------
  // software registers
  // ----------------------------------------------------------
  // mode control; load bits are strobes and are not stored
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode <= dpt_pkg::MODE_RESET;
    end else if (wr && idx == dpt_pkg::IDX_MODE) begin // [R15]
      mode <= dat_i[7:0] & ~(8'h01 << dpt_pkg::MODE_LOAD0)
                         & ~(8'h01 << dpt_pkg::MODE_LOAD1);
    end
  end

  // restart strobes, one cycle after the write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      load0 <= 1'b0;
      load1 <= 1'b0;
    end else begin
      load0 <= wr && idx == dpt_pkg::IDX_MODE &&
               dat_i[dpt_pkg::MODE_LOAD0]; // [R6]
      load1 <= wr && idx == dpt_pkg::IDX_MODE &&
               dat_i[dpt_pkg::MODE_LOAD1]; // [R6]
    end
  end

  // prescaler and initial count registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div0  <= dpt_pkg::PRE_RESET;
      div1  <= dpt_pkg::PRE_RESET;
      init0 <= dpt_pkg::CNT_RESET;
      init1 <= dpt_pkg::CNT_RESET;
    end else if (wr) begin
      if (idx == dpt_pkg::IDX_DIV0) div0 <= dat_i[7:0];
      if (idx == dpt_pkg::IDX_DIV1) div1 <= dat_i[7:0]; // [R13]
      if (idx == dpt_pkg::IDX_CNT0) init0 <= dat_i[7:0];
      if (idx == dpt_pkg::IDX_CNT1) init1 <= dat_i[7:0]; // [R14]
    end
  end

  // mask and cascade configuration
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mask    <= dpt_pkg::MASK_RESET;
      cascade <= 1'b0;
    end else if (wr) begin
      if (idx == dpt_pkg::IDX_MASK) mask <= dat_i[1:0];
      if (idx == dpt_pkg::IDX_CFG) cascade <= dat_i[dpt_pkg::CFG_CASCADE];
    end
  end

  // ----------------------------------------------------------
  // clock sources and timer input
  // ----------------------------------------------------------
  // internal timer clock: one tick every fourth system clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      intDiv <= 2'h0;
    end else begin
      intDiv <= intDiv + 2'h1;
    end
  end
  assign intTick = (intDiv == dpt_pkg::INT_DIV_LAST); // [R9]

  // pin synchroniser; only tinSync and tinLast feed the logic
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tinMeta <= 1'b0;
      tinSync <= 1'b0;
      tinLast <= 1'b0;
    end else begin
      tinMeta <= port3Line1TimerInput;
      tinSync <= tinMeta;
      tinLast <= tinSync;
    end
  end
  // rising edges only; input must stay stable two clocks per level
  assign tinEdge = tinSync && !tinLast;

  // timer one: internal clock modes versus external clock
  assign t1Internal = div1[dpt_pkg::PRE_SRC]; // [R2] [R9]
  assign gateOk = (mode[5:4] != dpt_pkg::TIN_GATE) || tinSync; // [R10]

  // ----------------------------------------------------------
  // counter channels
  // ----------------------------------------------------------
  // timer zero is fed only from the internal clock
  assign c0.tick      = intTick; // [R2]
  assign c0.load      = load0;
  assign c0.enable    = mode[dpt_pkg::MODE_EN0]; // [R6]
  assign c0.cont      = div0[dpt_pkg::PRE_CONT];
  assign c0.preDiv    = div0[7:2];
  assign c0.initCount = init0;
  assign c0.trigMode  = 1'b0;
  assign c0.trigEdge  = 1'b0;
  assign c0.retrig    = 1'b0;

  // timer one source: cascade, external edge, or gated clock
  assign c1.tick = cascade ? c0.eoc : // [R12]
                   t1Internal ? (intTick && gateOk) : tinEdge; // [R2]
  assign c1.load      = load1;
  assign c1.enable    = mode[dpt_pkg::MODE_EN1]; // [R6]
  assign c1.cont      = div1[dpt_pkg::PRE_CONT];
  assign c1.preDiv    = div1[7:2];
  assign c1.initCount = init1;
  assign c1.trigMode  = !cascade && t1Internal && mode[5]; // [R10]
  assign c1.trigEdge  = tinEdge;
  assign c1.retrig    = mode[5:4] == dpt_pkg::TIN_RETRIG; // [R10]

  dpt_channel u_ch0 (
    .clock (clock),
    .rstn  (rstn),
    .ch    (c0.chan)
  );

  dpt_channel u_ch1 (
    .clock (clock),
    .rstn  (rstn),
    .ch    (c1.chan)
  );

  // ----------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------
  // a status read clears, but a same-cycle event still sets
  always_comb begin
    next_stat = stat;
    if (rd && idx == dpt_pkg::IDX_STAT) begin
      next_stat = 2'h0;
    end
    next_stat = next_stat | {c1.eoc, c0.eoc}; // [R5]
  end

  // sticky status, level request and end-of-count pulses
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stat                <= 2'h0;
      irq                 <= 1'b0;
      timerZeroEndRequest <= 1'b0;
      timerOneEndRequest  <= 1'b0;
    end else begin
      stat                <= next_stat;
      irq                 <= |(stat & mask);
      timerZeroEndRequest <= c0.eoc; // [R5]
      timerOneEndRequest  <= c1.eoc; // [R5]
    end
  end

  // ----------------------------------------------------------
  // timer output line
  // ----------------------------------------------------------
  // toggle flop follows whichever timer is selected
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      outFlip <= 1'b0;
    end else if ((mode[7:6] == dpt_pkg::OUT_ZERO && c0.eoc) ||
                 (mode[7:6] == dpt_pkg::OUT_ONE && c1.eoc)) begin
      outFlip <= !outFlip; // [R17]
    end
  end

  // pin drive; clock choice shows the internal timer clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port3Line6TimerOutput   <= 1'b0;
      port3Line6TimerOutputEn <= 1'b0;
    end else begin
      port3Line6TimerOutput <= (mode[7:6] == dpt_pkg::OUT_CLK) ?
                               intDiv[1] : outFlip; // [R11]
      port3Line6TimerOutputEn <= mode[7:6] != dpt_pkg::OUT_OFF; // [R11]
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  sequence preRead;
    rd && (idx == dpt_pkg::IDX_DIV0 || idx == dpt_pkg::IDX_DIV1);
  endsequence

  sequence zeroToggle;
    mode[7:6] == dpt_pkg::OUT_ZERO && c0.eoc;
  endsequence

  pre_reads_zero_a: assert property (@(posedge clock) // [R8]
    disable iff (!rstn) preRead |=> ack_o && dat_o == 32'h0)
    else $error("prescaler read returned nonzero data");
  ack_single_a: assert property (@(posedge clock) // [R15]
    disable iff (!rstn) wbReq |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle answer");
  stat_set_a: assert property (@(posedge clock) // [R5]
    disable iff (!rstn) c1.eoc |=> stat[1] && timerOneEndRequest)
    else $error("timer one end did not set status");
  irq_level_a: assert property (@(posedge clock) // [R5]
    disable iff (!rstn) (stat[0] && mask[0]) |=> irq)
    else $error("unmasked status did not raise irq");
  timer_output_pin_flip_a: assert property (@(posedge clock) // [R17]
    disable iff (!rstn) zeroToggle |=> ##1
    port3Line6TimerOutput != $past(port3Line6TimerOutput))
    else $error("timer output did not toggle");
  cascade_tick_a: assert property (@(posedge clock) // [R12]
    disable iff (!rstn) cascade |-> c1.tick == c0.eoc)
    else $error("cascade not fed by timer zero");
  count_read_a: assert property (@(posedge clock) // [R14]
    disable iff (!rstn) rd && idx == dpt_pkg::IDX_CNT1
    |=> dat_o[7:0] == $past(c1.count))
    else $error("count read returned wrong value");

endmodule

// [dpt_pin_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------
// port side: drives the timer input pin
// ----------------------------------------------------------
module dpt_pin_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // requests from the bench
  input  wire logic       go,
  input  wire logic [3:0] nEdges,
  input  wire logic [2:0] halfPer,
  input  wire logic       gateHigh,
  // pin side
  output      logic       pin,
  output      logic       busy
);
  logic [4:0] left;
  logic [2:0] cnt;

  assign busy = (left != 5'h0);

  // burst of rising edges; long halves exercise the synchroniser
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin  <= 1'b0;
      left <= 5'h0;
      cnt  <= 3'h0;
    end else if (go) begin
      left <= {nEdges, 1'b0};
      cnt  <= 3'h0;
      pin  <= 1'b0;
    end else if (left != 5'h0) begin
      if (cnt == halfPer) begin
        cnt  <= 3'h0;
        pin  <= ~pin;
        left <= left - 5'h1;
      end else begin
        cnt <= cnt + 3'h1;
      end
    end else begin
      pin <= gateHigh; // idle level doubles as the gate level
    end
  end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        clock, rstn, cyc, stb, we, ack, irq, end0, end1;
  logic        tin, timer_output_pin, toutEn, go, gateHigh, busy, p;
  logic [9:0]  adr;
  logic [3:0]  sel, nEdges;
  logic [2:0]  halfPer;
  logic [31:0] datW, datR, v;
  int          n_mismatch, n_compared, seed, n0, n1, t0a, t0b, cycleNum;
  int          i, ini, dv, b0, b1, tr;

  dpt_timer dpt_timer_i (.clock(clock), .rstn(rstn), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW),
    .ack_o(ack), .dat_o(datR), .irq(irq), .timerZeroEndRequest(end0),
    .timerOneEndRequest(end1), .port3Line1TimerInput(tin),
    .port3Line6TimerOutput(timer_output_pin), .port3Line6TimerOutputEn(toutEn));
  dpt_pin_model dpt_pin_model_i (.clock(clock), .rstn(rstn), .go(go),
    .nEdges(nEdges), .halfPer(halfPer), .gateHigh(gateHigh), .pin(tin),
    .busy(busy));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; the answer time is never assumed
  task automatic wb(input logic w, input logic [7:0] x, input logic [7:0] d);
    int k;
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {x, 2'b00};
    datW <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (ack !== 1'b1 && k < 50);
    check(k < 50, 1);
    v = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] x, input logic [7:0] d);
    wb(1'b1, x, d);
  endtask
  task automatic rd(input logic [7:0] x, input logic [31:0] exp);
    wb(1'b0, x, 8'h00);
    check(v, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic waitEnd(input bit one, input int target, input int lim);
    int k;
    k = 0;
    while ((one ? n1 : n0) < target && k < lim) begin
      @(negedge clock);
      k++;
    end
    check(k < lim, 1);
  endtask
  task automatic pins(input int n, input int h);
    @(posedge clock);
    nEdges  <= n[3:0];
    halfPer <= h[2:0];
    go      <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(posedge clock);
    while (busy === 1'b1) @(posedge clock);
    tick(10);
  endtask
  // clocks between two ends: zero count means 256, zero divisor 64
  function automatic int span(input int c, input int d);
    return (c == 0 ? 256 : c) * (d == 0 ? 64 : d) * 4;
  endfunction
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // clock, end-of-count monitor, watchdog
  // ----------------------------------------------------------
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cycleNum++;
    if (end0 === 1'b1) begin
      t0a = t0b;
      t0b = cycleNum;
      n0++;
    end
    if (end1 === 1'b1) n1++;
  end
  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    results();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    {clock, rstn, cyc, stb, we, go, gateHigh} = '0;
    adr = '0;
    sel = 4'hf; // byte lane zero always enabled
    datW = '0;
    nEdges = '0;
    halfPer = 3'h2;
    seed = 49;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    // reset values, write-only and unmapped places read zero
    for (i = 0; i < 9; i++) begin
      rd(i < 5 ? 8'hf1 + i[7:0] : (i < 8 ? 8'hdb + i[7:0] : 8'h33), 0);
    end
    ini = $random(seed) & 32'hf0;
    wr(dpt_pkg::IDX_MODE, ini[7:0]);
    rd(dpt_pkg::IDX_MODE, ini);
    wr(dpt_pkg::IDX_DIV1, 8'hff);
    rd(dpt_pkg::IDX_DIV1, 0);
    wr(8'h33, 8'h5a);
    rd(8'h33, 0);
    // continuous periods, random and both range corners
    for (i = 0; i < 6; i++) begin
      ini = 2 + $unsigned($random(seed)) % 6;
      dv = 1 + $unsigned($random(seed)) % 3;
      if (i == 4) {ini, dv} = {32'd0, 32'd1};
      if (i == 5) {ini, dv} = {32'd1, 32'd0};
      wr(dpt_pkg::IDX_MODE, 8'h00);
      wr(dpt_pkg::IDX_DIV0, {dv[5:0], 2'b01});
      wr(dpt_pkg::IDX_CNT0, ini[7:0]);
      wr(dpt_pkg::IDX_MODE, 8'h43);
      b0 = n0;
      waitEnd(0, b0 + 2, 2600);
      tick(3);
      p = timer_output_pin;
      waitEnd(0, b0 + 3, 1300);
      check(t0b - t0a, span(ini, dv));
      tick(3);
      check(timer_output_pin, !p);
      check(toutEn, 1);
    end
    // single pass with stop, resume, restart and interrupt
    wr(dpt_pkg::IDX_MODE, 8'h00);
    wb(1'b0, dpt_pkg::IDX_STAT, 8'h00);
    wr(dpt_pkg::IDX_DIV0, 8'h10);
    wr(dpt_pkg::IDX_CNT0, 8'h03);
    wr(dpt_pkg::IDX_MODE, 8'h03);
    tick(20);
    wr(dpt_pkg::IDX_MODE, 8'h00);
    wb(1'b0, dpt_pkg::IDX_CNT0, 8'h00);
    ini = v;
    tick(40);
    rd(dpt_pkg::IDX_CNT0, ini);
    b0 = n0;
    wr(dpt_pkg::IDX_MODE, 8'h02);
    waitEnd(0, b0 + 1, 100);
    tick(100);
    check(n0 - b0, 1);
    rd(dpt_pkg::IDX_CNT0, 0);
    check(irq, 0);
    wr(dpt_pkg::IDX_MASK, 8'h01);
    tick(3);
    check(irq, 1);
    rd(dpt_pkg::IDX_STAT, 1);
    tick(3);
    check(irq, 0);
    wr(dpt_pkg::IDX_MODE, 8'h03);
    waitEnd(0, b0 + 2, 100);
    wb(1'b0, dpt_pkg::IDX_STAT, 8'h00);
    // timer one on external edges, source chosen by prescaler
    wr(dpt_pkg::IDX_DIV1, 8'h04);
    wr(dpt_pkg::IDX_CNT1, 8'h03);
    wr(dpt_pkg::IDX_MODE, 8'h8c);
    b1 = n1;
    p = timer_output_pin;
    pins(2, 2 + $unsigned($random(seed)) % 4);
    check(n1 - b1, 0);
    pins(1, 2 + $unsigned($random(seed)) % 4);
    check(n1 - b1, 1);
    check(timer_output_pin, !p);
    rd(dpt_pkg::IDX_CNT1, 0);
    rd(dpt_pkg::IDX_STAT, 2);
    // gate, one-shot trigger and retrigger on internal ticks
    wr(dpt_pkg::IDX_DIV1, 8'h06);
    wr(dpt_pkg::IDX_CNT1, 8'h05);
    wr(dpt_pkg::IDX_MODE, 8'h1c);
    tick(60);
    rd(dpt_pkg::IDX_CNT1, 5);
    b1 = n1;
    gateHigh <= 1'b1;
    waitEnd(1, b1 + 1, 60);
    gateHigh <= 1'b0;
    wr(dpt_pkg::IDX_CNT1, 8'h02);
    wr(dpt_pkg::IDX_MODE, 8'h2c);
    b1 = n1;
    tick(40);
    check(n1 - b1, 0);
    pins(1, 2);
    waitEnd(1, b1 + 1, 40);
    wr(dpt_pkg::IDX_CNT1, 8'h10);
    wr(dpt_pkg::IDX_MODE, 8'h3c);
    b1 = n1;
    pins(6, 7);
    check(n1 - b1, 0);
    waitEnd(1, b1 + 1, 100);
    // cascade: timer one counts timer zero ends
    wr(dpt_pkg::IDX_CFG, 8'h01);
    wr(dpt_pkg::IDX_DIV0, 8'h05);
    wr(dpt_pkg::IDX_CNT0, 8'h02);
    wr(dpt_pkg::IDX_DIV1, 8'h04);
    wr(dpt_pkg::IDX_CNT1, 8'h03);
    b0 = n0;
    b1 = n1;
    wr(dpt_pkg::IDX_MODE, 8'h0f);
    waitEnd(1, b1 + 1, 100);
    check(n0 - b0, 3);
    // internal clock onto the output line
    wr(dpt_pkg::IDX_MODE, 8'hc0);
    tr = 0;
    p = timer_output_pin;
    repeat (16) begin
      @(negedge clock);
      tr += (timer_output_pin !== p);
      p = timer_output_pin;
    end
    check(tr > 2, 1);
    results();
  end
endmodule
